// ---- design/tu_front_panel.sv ----
// trip unit front panel: protection states, trip command, leds, test pushbutton
//
// Notes on behaviour
// - power led lit (steady or blinking) while energized, dark while de-energized except during a button recall after energy loss
// - power led lit by default; steady or blinking chosen by register
// - energized unit shows live alarms and latched trips on their leds; the instant led shows trips only
// - de-energized unit shows only the last off or trip event, on button query
// - overload has pre-alarm and alarm leds; others alarm leds; instant trip only
// - selective and earth delay and curve come from their own switch groups
// - setting changes during any alarm wait until all alarms clear
// - thresholds are multiples of the rated current from the rating plug
// - neutral setting enables and scales neutral protection; frequency setting selected
// - holding button about one second while energized clears trip indication at release
// - off after energy loss: button press lights power led about four seconds
// - off after a trip: button press lights that trip led about four seconds
// - measurement above threshold puts the protection into pre-alarm or alarm
// - alarm lasting the configured delay raises the trip coil command
// - measurement falling below threshold before the delay drops alarm, no trip
// - only enabled protections trip; all start from a default configuration
// - selective threshold at or below overload threshold raises a configuration alarm
`default_nettype none
module tu_front_panel
  import tu_pkg::*;
#(
  parameter int TICK_CYCLES = TU_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic powered,
  input wire logic [15:0] rated_current,
  input wire tu_meas_type meas,
  input wire tu_dip_type dip,
  input wire logic test_pushbutton,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output tu_led_type led,
  output logic trip_coil,
  output logic cfg_alarm,
  output logic [1:0] neutral_scale,
  output logic line_freq_60
);

  // ************************************************************
  // millisecond tick
  // ************************************************************
  logic [15:0] tick_cnt_ff;
  logic [15:0] nxt_tick_cnt;
  logic tick;

  assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1));
  assign nxt_tick_cnt = tick ? 16'h0000 : tick_cnt_ff + 16'h0001;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [4:0] ctrl_ff;
  logic [31:0] rd_data_ff;
  logic [31:0] nxt_rd_data;
  logic [31:0] status_word;
  logic [3:0] en_mask;
  logic blink_mode;
  logic wr_ctrl;

  assign wr_ctrl = wr_en && (addr == TU_ADDR_CTRL);
  assign en_mask = ctrl_ff[TU_CTRL_EN_LSB +: TU_NCH];
  assign blink_mode = ctrl_ff[TU_CTRL_BLINK_BIT];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_ff <= TU_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= wr_data[4:0];
    end
  end

  // ************************************************************
  // settings shadow
  // ************************************************************
  tu_dip_type active_ff;
  logic any_alarm;
  logic pending;

  assign pending = (dip != active_ff);

  // pending switches only move over when no protection is alarmed
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      active_ff <= TU_DIP_RESET;
    end else if (!any_alarm) begin
      active_ff <= dip;
    end
  end

  assign neutral_scale = active_ff.neutral;
  assign line_freq_60 = active_ff.freq_60;

  // ************************************************************
  // per channel protection
  // ************************************************************
  logic [15:0] ch_meas [TU_NCH];
  logic [2:0] ch_thr [TU_NCH];
  logic [2:0] ch_dly [TU_NCH];
  logic [TU_NCH-1:0] ch_inverse;
  logic [31:0] thr_x8 [TU_NCH];
  logic [31:0] meas_x8 [TU_NCH];
  logic [15:0] dly_ms [TU_NCH];
  logic [15:0] cnt_ff [TU_NCH];
  logic [15:0] nxt_cnt [TU_NCH];
  logic [TU_NCH-1:0] enabled;
  logic [TU_NCH-1:0] exceed;
  logic [TU_NCH-1:0] alarm;
  logic [TU_NCH-1:0] fast;
  logic [TU_NCH-1:0] expired;
  logic [TU_NCH-1:0] fire;
  logic neutral_exceed;
  logic pre_alarm;

  assign ch_meas[TU_CH_OVL] = meas.phase;
  assign ch_meas[TU_CH_SEL] = meas.phase;
  assign ch_meas[TU_CH_INST] = meas.phase;
  assign ch_meas[TU_CH_EARTH] = meas.earth;
  assign ch_thr[TU_CH_OVL] = active_ff.ovl_thr;
  assign ch_thr[TU_CH_SEL] = active_ff.sel_thr;
  assign ch_thr[TU_CH_INST] = active_ff.inst_thr;
  assign ch_thr[TU_CH_EARTH] = active_ff.earth_thr;
  assign ch_dly[TU_CH_OVL] = active_ff.ovl_dly;
  assign ch_dly[TU_CH_SEL] = active_ff.sel_dly;
  assign ch_dly[TU_CH_INST] = TU_INST_DLY_CODE;
  assign ch_dly[TU_CH_EARTH] = active_ff.earth_dly;
  assign ch_inverse = {active_ff.earth_inverse, 1'b0, active_ff.sel_inverse, 1'b0};

  // neutral pole checked against the overload level scaled by half steps
  assign neutral_exceed = (active_ff.neutral != 2'h0) &&
    ({13'h0000, meas.neutral, 3'h0} > 32'(thr_x8[TU_CH_OVL] * 32'(active_ff.neutral)) >> 1);

  assign pre_alarm = powered && enabled[TU_CH_OVL] &&
    (32'(meas_x8[TU_CH_OVL] * 32'(TU_PRE_DEN)) > 32'(thr_x8[TU_CH_OVL] * 32'(TU_PRE_NUM)));

  assign any_alarm = |alarm;

  genvar i;
  generate
    for (i = 0; i < TU_NCH; i++) begin : g_ch
      assign thr_x8[i] = 32'(rated_current) * 32'(ch_thr[i]) * 32'(TU_THR_STEP[i]);
      assign meas_x8[i] = {13'h0000, ch_meas[i], 3'h0};
      assign dly_ms[i] = 16'(ch_dly[i] * TU_DLY_UNIT_MS[i]);
      // a zero threshold code or a cleared mask bit keeps the channel silent
      assign enabled[i] = (ch_thr[i] != 3'h0) && en_mask[i];
      if (i == TU_CH_OVL) begin : g_ovl
        assign exceed[i] = (meas_x8[i] > thr_x8[i]) || neutral_exceed;
      end else begin : g_oth
        assign exceed[i] = meas_x8[i] > thr_x8[i];
      end
      assign alarm[i] = powered && enabled[i] && exceed[i];
      assign fast[i] = ch_inverse[i] && (meas_x8[i] > (thr_x8[i] << 1));
      assign expired[i] = cnt_ff[i] >= dly_ms[i];
      assign fire[i] = alarm[i] && expired[i];
      // timing restarts as soon as the level drops back
      assign nxt_cnt[i] = !alarm[i] ? 16'h0000 :
        (tick && !expired[i]) ? cnt_ff[i] + (fast[i] ? 16'h0002 : 16'h0001) :
        cnt_ff[i];
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          cnt_ff[i] <= 16'h0000;
        end else begin
          cnt_ff[i] <= nxt_cnt[i];
        end
      end
    end
  endgenerate

  // ************************************************************
  // trip command and configuration check
  // ************************************************************
  logic trip_ff;
  logic cfg_ff;
  logic nxt_cfg;

  assign nxt_cfg = enabled[TU_CH_SEL] && enabled[TU_CH_OVL] &&
    (thr_x8[TU_CH_SEL] <= thr_x8[TU_CH_OVL]);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trip_ff <= 1'b0;
      cfg_ff <= 1'b0;
    end else begin
      trip_ff <= |fire;
      cfg_ff <= nxt_cfg;
    end
  end

  assign trip_coil = trip_ff;
  assign cfg_alarm = cfg_ff;

  // ************************************************************
  // test pushbutton
  // ************************************************************
  logic btn_ff;
  logic [4:0] deb_ms_ff;
  logic [4:0] nxt_deb_ms;
  logic [10:0] hold_ms_ff;
  logic [10:0] nxt_hold_ms;
  logic btn_rise;
  logic btn_fall;
  logic long_release;
  logic deb_done;

  assign deb_done = tick && (deb_ms_ff == 5'(TU_DEBOUNCE_MS - 1));
  // bounce restarts the stability window
  assign nxt_deb_ms = (test_pushbutton == btn_ff) ? 5'h00 :
    deb_done ? 5'h00 : tick ? deb_ms_ff + 5'h01 : deb_ms_ff;
  assign btn_rise = deb_done && test_pushbutton && !btn_ff;
  assign btn_fall = deb_done && !test_pushbutton && btn_ff;
  // counter saturates, so very long holds still count as long
  assign nxt_hold_ms = btn_rise ? 11'h000 :
    (btn_ff && tick && (hold_ms_ff != 11'(TU_TEST_RESET_MS))) ? hold_ms_ff + 11'h001 :
    hold_ms_ff;
  assign long_release = btn_fall && (hold_ms_ff == 11'(TU_TEST_RESET_MS));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      btn_ff <= 1'b0;
      deb_ms_ff <= 5'h00;
      hold_ms_ff <= 11'h000;
    end else begin
      btn_ff <= (btn_rise || btn_fall) ? test_pushbutton : btn_ff;
      deb_ms_ff <= nxt_deb_ms;
      hold_ms_ff <= nxt_hold_ms;
    end
  end

  // ************************************************************
  // event memory
  // ************************************************************
  logic [TU_NCH-1:0] tripped_ff;
  logic [TU_NCH-1:0] nxt_tripped;
  logic loss_ff;
  logic powered_ff;
  logic power_fall;
  logic [11:0] recall_ms_ff;
  logic [11:0] nxt_recall_ms;
  logic recall;

  // a trip in the same cycle as the clearing release is kept
  assign nxt_tripped = fire | (long_release && powered ? {TU_NCH{1'b0}} : tripped_ff);
  assign power_fall = powered_ff && !powered;
  assign recall = (recall_ms_ff != 12'h000);
  assign nxt_recall_ms = (btn_rise && !powered) ? 12'(TU_RECALL_MS) :
    (powered ? 12'h000 : (recall && tick) ? recall_ms_ff - 12'h001 : recall_ms_ff);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tripped_ff <= {TU_NCH{1'b0}};
      loss_ff <= 1'b0;
      powered_ff <= 1'b0;
      recall_ms_ff <= 12'h000;
    end else begin
      tripped_ff <= nxt_tripped;
      loss_ff <= power_fall ? ~|tripped_ff : loss_ff;
      powered_ff <= powered;
      recall_ms_ff <= nxt_recall_ms;
    end
  end

  // ************************************************************
  // leds
  // ************************************************************
  logic [8:0] blink_ms_ff;
  logic [8:0] nxt_blink_ms;
  logic blink_ph_ff;
  logic blink_wrap;
  tu_led_type led_ff;
  tu_led_type nxt_led;
  logic [TU_NCH-1:0] show;

  assign blink_wrap = tick && (blink_ms_ff == 9'(TU_BLINK_MS - 1));
  assign nxt_blink_ms = blink_wrap ? 9'h000 : tick ? blink_ms_ff + 9'h001 : blink_ms_ff;
  // energized: live alarms plus latched trips; off: only the recalled trip
  assign show = powered ? (alarm | tripped_ff) :
    (recall ? tripped_ff : {TU_NCH{1'b0}});

  assign nxt_led.power = powered ? (!blink_mode || blink_ph_ff) :
    (recall && loss_ff);
  assign nxt_led.ovl_pre = powered && pre_alarm && !alarm[TU_CH_OVL];
  assign nxt_led.ovl_alarm = show[TU_CH_OVL];
  assign nxt_led.sel_alarm = show[TU_CH_SEL];
  // the instant led shows trips only, never a running alarm
  assign nxt_led.inst_trip = powered ? tripped_ff[TU_CH_INST] : show[TU_CH_INST];
  assign nxt_led.earth_alarm = show[TU_CH_EARTH];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      blink_ms_ff <= 9'h000;
      blink_ph_ff <= 1'b1;
      led_ff <= '0;
    end else begin
      blink_ms_ff <= nxt_blink_ms;
      blink_ph_ff <= blink_wrap ? !blink_ph_ff : blink_ph_ff;
      led_ff <= nxt_led;
    end
  end

  assign led = led_ff;

  // ************************************************************
  // read path
  // ************************************************************
  assign status_word = {19'h00000, trip_ff, pending, cfg_ff, loss_ff, tripped_ff,
    pre_alarm, alarm};
  assign nxt_rd_data = !rd_en ? 32'h00000000 :
    (addr == TU_ADDR_CTRL) ? {27'h0000000, ctrl_ff} :
    (addr == TU_ADDR_STATUS) ? status_word :
    (addr == TU_ADDR_SETTINGS) ? {6'h00, active_ff} :
    32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_data_ff <= 32'h00000000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

endmodule
`default_nettype wire

// ---- design/tu_pkg.sv ----
// shared constants and types of the trip unit front panel logic
`default_nettype none
package tu_pkg;

  // ************************************************************
  // channels
  // ************************************************************
  localparam int TU_NCH = 4;
  localparam int TU_CH_OVL = 0;
  localparam int TU_CH_SEL = 1;
  localparam int TU_CH_INST = 2;
  localparam int TU_CH_EARTH = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int TU_CLK_NS = 20;
  localparam int TU_MS_NS = 1000000;
  localparam int TU_TICK_CYCLES = TU_MS_NS / TU_CLK_NS;
  localparam int TU_DEBOUNCE_MS = 20;
  localparam int TU_TEST_RESET_MS = 1000;
  localparam int TU_RECALL_MS = 4000;
  localparam int TU_BLINK_MS = 500;

  // ************************************************************
  // protection scaling
  // ************************************************************
  // threshold = rated * code * step / 8, code 0 switches the protection off
  localparam logic [4:0] TU_THR_STEP [TU_NCH] = '{5'h01, 5'h08, 5'h10, 5'h01};
  // delay = code * unit in ms; the instant channel uses a fixed code
  localparam logic [11:0] TU_DLY_UNIT_MS [TU_NCH] = '{12'hBB8, 12'h032, 12'h00A, 12'h064};
  localparam logic [2:0] TU_INST_DLY_CODE = 3'h1;
  localparam logic [3:0] TU_PRE_NUM = 4'h9;
  localparam logic [3:0] TU_PRE_DEN = 4'hA;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] TU_ADDR_CTRL = 4'h0;
  localparam logic [3:0] TU_ADDR_STATUS = 4'h4;
  localparam logic [3:0] TU_ADDR_SETTINGS = 4'h8;
  localparam int TU_CTRL_BLINK_BIT = 0;
  localparam int TU_CTRL_EN_LSB = 1;
  localparam logic [4:0] TU_CTRL_RESET = 5'h1E;
  localparam int TU_ST_ALARM_LSB = 0;
  localparam int TU_ST_PRE_BIT = 4;
  localparam int TU_ST_TRIPPED_LSB = 5;
  localparam int TU_ST_LOSS_BIT = 9;
  localparam int TU_ST_CFG_BIT = 10;
  localparam int TU_ST_PEND_BIT = 11;
  localparam int TU_ST_TRIP_BIT = 12;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [2:0] ovl_thr;
    logic [2:0] ovl_dly;
    logic [2:0] sel_thr;
    logic [2:0] sel_dly;
    logic sel_inverse;
    logic [2:0] inst_thr;
    logic [2:0] earth_thr;
    logic [2:0] earth_dly;
    logic earth_inverse;
    logic [1:0] neutral;
    logic freq_60;
  } tu_dip_type;

  // every code 4, both inverse curves off, neutral off, 50 hz
  localparam tu_dip_type TU_DIP_RESET = 26'h2491240;

  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] neutral;
    logic [15:0] earth;
  } tu_meas_type;

  typedef struct packed {
    logic power;
    logic ovl_pre;
    logic ovl_alarm;
    logic sel_alarm;
    logic inst_trip;
    logic earth_alarm;
  } tu_led_type;

endpackage
`default_nettype wire

// ---- verification/tu_front_panel_sva.sv ----
// port assertions for the trip unit front panel
`default_nettype none
module tu_fp_chk
  import tu_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic powered,
  input wire tu_meas_type meas,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire tu_led_type led,
  input wire logic trip_coil,
  input wire logic [1:0] neutral_scale,
  input wire logic line_freq_60
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd(logic [3:0] a);
    rd_en && addr == a;
  endsequence
  sequence s_ctrl_wr;
    wr_en && addr == TU_ADDR_CTRL;
  endsequence
  wire logic mapped = addr == TU_ADDR_CTRL || addr == TU_ADDR_STATUS || addr == TU_ADDR_SETTINGS;
  a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (rd_en && !mapped |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (s_ctrl_wr ##1 !wr_en ##1 s_rd(TU_ADDR_CTRL) |=>
    rd_data == {27'h0, $past(wr_data[4:0], 3)})
    else $error("control readback differs from write");
  a_set_outputs: assert property (s_rd(TU_ADDR_SETTINGS) |=>
    rd_data[2:0] == {$past(neutral_scale), $past(line_freq_60)} && rd_data[31:26] == 6'h0)
    else $error("settings read differs from active outputs");
  a_status_trip: assert property (s_rd(TU_ADDR_STATUS) |=>
    rd_data[12] == $past(trip_coil))
    else $error("status trip bit differs from trip coil");
  a_trip_powered: assert property (trip_coil |-> $past(powered))
    else $error("trip coil while unpowered");
  a_unpowered_quiet: assert property (!powered [*2] |-> !trip_coil)
    else $error("trip coil held after power loss");
  a_quiet_no_trip: assert property ((meas == '0) [*3] |-> !trip_coil)
    else $error("trip coil with no current");
  // the instant led follows the trip latch, so it lights one cycle after the coil
  a_trip_shows_led: assert property (trip_coil && powered |-> ##1
    (led.ovl_alarm || led.sel_alarm || led.inst_trip || led.earth_alarm))
    else $error("trip coil with no alarm led");
endmodule
bind tu_front_panel tu_fp_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .powered(powered), .meas(meas), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .led(led), .trip_coil(trip_coil),
  .neutral_scale(neutral_scale), .line_freq_60(line_freq_60));
`default_nettype wire

// ---- verification/tu_panel_model.sv ----
// operator pushbutton and breaker trip coil stand-in
`default_nettype none
module tu_panel_model (
  input wire logic ref_clk,
  input wire logic trip_coil,
  output logic test_pushbutton
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_coil = 0;
  logic coil_q = 1'b0;
  initial test_pushbutton = 1'b0;
  // contacts chatter on make, so the debounce is really exercised
  task automatic press(input int n);
    repeat (3) begin
      @(posedge ref_clk);
      test_pushbutton <= ~test_pushbutton;
    end
    repeat (n) @(posedge ref_clk);
    test_pushbutton <= 1'b0;
  endtask
  // coil counts each new trip command once
  always @(posedge ref_clk) begin
    coil_q <= trip_coil;
    if (trip_coil === 1'b1 && coil_q !== 1'b1) n_coil++;
  end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the trip unit front panel
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tu_pkg::*;
  logic ref_clk, resetn, powered, wr_en, rd_en, trip_coil, cfg_alarm, line_freq_60;
  wire logic test_pushbutton;
  logic [15:0] rated_current;
  tu_meas_type meas;
  tu_dip_type dip;
  tu_led_type led;
  logic [3:0] addr;
  logic [31:0] wr_data, rd_data, d;
  logic [1:0] neutral_scale;
  int n_mismatch, tests_run, c, k;
  tu_front_panel #(.TICK_CYCLES(10)) uut (.ref_clk(ref_clk), .resetn(resetn),
    .powered(powered), .rated_current(rated_current), .meas(meas), .dip(dip),
    .test_pushbutton(test_pushbutton), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .led(led), .trip_coil(trip_coil),
    .cfg_alarm(cfg_alarm), .neutral_scale(neutral_scale), .line_freq_60(line_freq_60));
  tu_panel_model panel (.ref_clk(ref_clk), .trip_coil(trip_coil),
    .test_pushbutton(test_pushbutton));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic print_verdict();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp=%b got=%b", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask
  task automatic wait_trip(input int lim, output int n);
    n = 0;
    while (trip_coil !== 1'b1) begin
      cyc(1);
      n++;
      if (n > lim) begin
        n_mismatch++;
        $display("CHECK FAILED trip_coil exp=1 got=%b", trip_coil);
        print_verdict();
      end
    end
  endtask
  task automatic quiet(input int n);
    k = 0;
    repeat (n) begin
      cyc(1);
      k += (trip_coil === 1'b1);
    end
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    resetn = 1'b0;
    powered = 1'b1;
    rated_current = 16'h0064;
    meas = '0;
    dip = TU_DIP_RESET;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 32'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(2);
    chk_flag("power_led", 1'b1, led.power);
    chk_flag("cfg_ok", 1'b0, cfg_alarm);
    rd(TU_ADDR_CTRL, d);
    chk_reg("ctrl", {27'h0, TU_CTRL_RESET}, d);
    rd(TU_ADDR_SETTINGS, d);
    chk_reg("settings", {6'h0, TU_DIP_RESET}, d);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, d);
    chk_reg("unmapped", 32'h0, d);
    wr(TU_ADDR_CTRL, 32'h0000001F);
    rd(TU_ADDR_CTRL, d);
    chk_reg("ctrl_blink", 32'h0000001F, d);
    c = 0;
    quiet(1);
    repeat (12000) begin
      cyc(1);
      c += (led.power === 1'b1);
    end
    chk_flag("blink_on", 1'b1, c > 0);
    chk_flag("blink_off", 1'b1, c < 12000);
    wr(TU_ADDR_CTRL, 32'h0000001E);
    $display("test registers done");
    meas.phase <= 16'h0030;
    cyc(5);
    chk_flag("pre_led", 1'b1, led.ovl_pre);
    chk_flag("ovl_led", 1'b0, led.ovl_alarm);
    rd(TU_ADDR_STATUS, d);
    chk_reg("status_pre", 32'h10, d & 32'h1F);
    @(posedge ref_clk);
    meas.phase <= 16'h01F4;
    wait_trip(2600, c);
    chk_flag("trip_late", 1'b1, c >= 1900);
    chk_flag("sel_led", 1'b1, led.sel_alarm);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    cyc(5);
    chk_flag("trip_drop", 1'b0, trip_coil);
    $display("test trip done");
    @(posedge ref_clk);
    meas.phase <= 16'h01F4;
    dip.freq_60 <= 1'b1;
    rd(TU_ADDR_STATUS, d);
    chk_flag("pending", 1'b1, d[TU_ST_PEND_BIT]);
    chk_flag("freq_held", 1'b0, line_freq_60);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    cyc(3);
    chk_flag("freq_new", 1'b1, line_freq_60);
    rd(TU_ADDR_SETTINGS, d);
    chk_reg("settings_new", {6'h0, dip}, d);
    // an alarm dropped part way must start its delay again from zero
    @(posedge ref_clk);
    meas.phase <= 16'h01F4;
    quiet(1500);
    chk_reg("early_trip", 32'h0, k);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    cyc(3);
    @(posedge ref_clk);
    meas.phase <= 16'h01F4;
    wait_trip(2600, c);
    chk_flag("restart", 1'b1, c >= 1900);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    cyc(2);
    quiet(2500);
    chk_reg("no_trip", 32'h0, k);
    wr(TU_ADDR_CTRL, 32'h0000001A);
    meas.phase <= 16'h01F4;
    quiet(2500);
    chk_reg("masked_trip", 32'h0, k);
    rd(TU_ADDR_STATUS, d);
    chk_reg("alarms", 32'h1, d & 32'hF);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    wr(TU_ADDR_CTRL, 32'h0000001E);
    $display("test settings done");
    panel.press(3000);
    cyc(400);
    rd(TU_ADDR_STATUS, d);
    chk_flag("latch_kept", 1'b1, d[TU_ST_TRIPPED_LSB + 1]);
    panel.press(11000);
    cyc(400);
    rd(TU_ADDR_STATUS, d);
    chk_flag("latch_clear", 1'b0, d[TU_ST_TRIPPED_LSB + 1]);
    chk_flag("sel_led_off", 1'b0, led.sel_alarm);
    $display("test pushbutton done");
    @(posedge ref_clk);
    powered <= 1'b0;
    cyc(10);
    chk_reg("leds_dark", 32'h0, {26'h0, led});
    panel.press(500);
    cyc(1);
    chk_flag("recall_power", 1'b1, led.power);
    chk_flag("recall_sel", 1'b0, led.sel_alarm);
    cyc(39000);
    chk_flag("recall_hold", 1'b1, led.power);
    cyc(1500);
    chk_flag("recall_end", 1'b0, led.power);
    @(posedge ref_clk);
    powered <= 1'b1;
    meas.phase <= 16'h01F4;
    wait_trip(2600, c);
    @(posedge ref_clk);
    meas.phase <= 16'h0000;
    cyc(5);
    @(posedge ref_clk);
    powered <= 1'b0;
    cyc(10);
    panel.press(500);
    cyc(1);
    chk_flag("recall_trip", 1'b1, led.sel_alarm);
    chk_flag("recall_nopow", 1'b0, led.power);
    chk_reg("coil_pulses", 32'h3, panel.n_coil);
    $display("test recall done");
    print_verdict();
  end
endmodule
`default_nettype wire
